// ---- rtl/pxpu_pkg.sv ----
// Package for the port expansion and pull-up control block.
// Assumes an 8-bit register port with 16-bit addresses.
package pxpu_pkg;
	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [15:0] OFF_MEM_EXP_CTRL = 16'hFFC4;
	localparam logic [15:0] OFF_PU_OPT_LOW   = 16'hFFC8;
	localparam logic [15:0] OFF_PU_OPT_HIGH  = 16'hFFC9;
	localparam logic [15:0] OFF_DIR_P0       = 16'hFF20;
	localparam logic [15:0] OFF_DIR_P1       = 16'hFF21;
	localparam logic [15:0] OFF_DIR_P3       = 16'hFF23;
	localparam logic [15:0] OFF_DIR_P5       = 16'hFF25;
	localparam logic [15:0] OFF_DIR_P8       = 16'hFF28;
	localparam logic [15:0] OFF_DIR_P9       = 16'hFF29;
	localparam logic [15:0] OFF_ALT_P0       = 16'hFF40;
	localparam logic [15:0] OFF_ALT_P3       = 16'hFF43;
	localparam logic [15:0] OFF_ALT_P8       = 16'hFF48;

	// -----------------------------------------------------------------
	// Field masks and positions
	// -----------------------------------------------------------------
	localparam logic [7:0] MM_MASK_CODE = 8'h07;
	localparam logic [7:0] MM_MASK_SIZE = 8'h60;
	localparam logic [7:0] PUL_MASK     = 8'h3F;
	localparam logic [7:0] PUH_MASK     = 8'h03;
	localparam logic [7:0] MASK_7BIT    = 8'h7F;
	localparam logic [7:0] MASK_6BIT    = 8'h3F;
	localparam logic [7:0] MASK_4BIT    = 8'h0F;
	localparam int MM_SIZE_LSB = 5;
	localparam int PUL_P0 = 0;
	localparam int PUL_P1 = 1;
	localparam int PUL_P2 = 2;
	localparam int PUL_P3 = 3;
	localparam int PUL_P4 = 4;
	localparam int PUL_P5 = 5;
	localparam int PUH_P8 = 0;
	localparam int PUH_P9 = 1;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] MM_RESET_A = 8'h60;
	localparam logic [7:0] MM_RESET_B = 8'h20;
	localparam logic [7:0] MM_RESET_C = 8'h00;
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_DIR    = 8'hFF;

	// -----------------------------------------------------------------
	// Expansion codes and address-line masks of the high port
	// -----------------------------------------------------------------
	localparam logic [2:0] EXP_SC_IN  = 3'h0;
	localparam logic [2:0] EXP_SC_OUT = 3'h1;
	localparam logic [2:0] EXP_256    = 3'h3;
	localparam logic [2:0] EXP_4K     = 3'h4;
	localparam logic [2:0] EXP_16K    = 3'h5;
	localparam logic [2:0] EXP_FULL   = 3'h7;
	// Reserved code, never to be written; decoded as full expansion
	localparam logic [2:0] EXP_RSV_HI = 3'h6;
	localparam logic [7:0] ADDR_NONE  = 8'h00;
	localparam logic [7:0] ADDR_4K    = 8'h0F;
	localparam logic [7:0] ADDR_16K   = 8'h3F;
	localparam logic [7:0] ADDR_FULL  = 8'hFF;
endpackage : pxpu_pkg

// ---- rtl/pxpu_top.sv ----
// Port expansion mode register and internal pull-up gating.
// Assumes a single-cycle register port and pads that take the
// pull-up and bus-function levels from the outputs below.
//
// Operation
// - Codes 000/001: high port is general I/O, low port input/output.
// - 256-byte code: low port is address/data, high port general I/O.
// - 4K code: low port bus, high pins 0-3 address, rest general.
// - 16K code: low port bus, high pins 0-5 address, top two general.
// - Full code: every low and high port pin serves the bus.
// - Programmable variant: two bits pick memory size; else fixed.
// - Expansion register reset value is a per-product parameter.
// - Expansion register bits 3, 4, 7 read zero, writes ignored.
// - Ports 0,1,3,8: pull-up when not alternate, option set, input.
// - Alternate-function pin never gets a pull-up.
// - Port-2 option bit pulls up all five upper pins together.
// - Lowest port-2 pin never gets a pull-up.
// - Port 4 pulls up all pins when option set and input mode.
// - Port 5 pull-up needs option, no expansion, direction input.
// - Port 9 pull-up needs high option bit, no expansion, input.
// - Any expansion mode disables port 4, 5, 9 pull-ups.
// - Upper unused pull-up option bits read zero, writes ignored.
// - Direction bit one means input, zero means output.
// - Alternate-function bit one overrides latch and direction.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module pxpu_top #(
	parameter logic [7:0] MM_RESET  = pxpu_pkg::MM_RESET_C,
	parameter bit         SIZE_PROG = 1'b1
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	output logic      [7:0]  pu_p0_o,
	output logic      [7:0]  pu_p1_o,
	output logic      [5:0]  pu_p2_o,
	output logic      [6:0]  pu_p3_o,
	output logic      [7:0]  pu_p4_o,
	output logic      [7:0]  pu_p5_o,
	output logic      [5:0]  pu_p8_o,
	output logic      [3:0]  pu_p9_o,
	output logic      [7:0]  alt_p0_o,
	output logic      [6:0]  alt_p3_o,
	output logic      [5:0]  alt_p8_o,
	output logic      [7:0]  dir_p0_o,
	output logic      [7:0]  dir_p1_o,
	output logic      [6:0]  dir_p3_o,
	output logic      [7:0]  dir_p5_o,
	output logic      [5:0]  dir_p8_o,
	output logic      [3:0]  dir_p9_o,
	output logic             p4_bus_o,
	output logic             p4_out_o,
	output logic      [7:0]  p5_addr_o,
	output logic             p9_bus_o,
	output logic      [1:0]  mem_size_o
);
	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] mm;
		logic [7:0] pullup_option_low;
		logic [7:0] pullup_option_high;
		logic [7:0] pm0;
		logic [7:0] pm1;
		logic [7:0] pm3;
		logic [7:0] pm5;
		logic [7:0] pm8;
		logic [7:0] pm9;
		logic [7:0] pmc0;
		logic [7:0] pmc3;
		logic [7:0] pmc8;
		logic [7:0] rdata;
		logic [7:0] pu0;
		logic [7:0] pu1;
		logic [5:0] pu2;
		logic [6:0] pu3;
		logic [7:0] pu4;
		logic [7:0] pu5;
		logic [5:0] pu8;
		logic [3:0] pu9;
		logic       p4_bus;
		logic       p4_out;
		logic [7:0] p5_addr;
		logic       p9_bus;
	} pxpu_state_t;

	pxpu_state_t s_reg;
	pxpu_state_t s_next;
	logic [7:0]  mm_wmask;
	logic [2:0]  code;
	logic        exp_on;

	// Size bits are live only on the programmable variant
	assign mm_wmask = SIZE_PROG ?
		(pxpu_pkg::MM_MASK_CODE | pxpu_pkg::MM_MASK_SIZE) :
		pxpu_pkg::MM_MASK_CODE;

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rdata = pxpu_pkg::RST_ZERO;
		if (rd_i) begin
			case (addr_i)
				pxpu_pkg::OFF_MEM_EXP_CTRL: s_next.rdata = s_reg.mm;
				pxpu_pkg::OFF_PU_OPT_LOW:   s_next.rdata = s_reg.pullup_option_low;
				pxpu_pkg::OFF_PU_OPT_HIGH:  s_next.rdata = s_reg.pullup_option_high;
				pxpu_pkg::OFF_DIR_P0:       s_next.rdata = s_reg.pm0;
				pxpu_pkg::OFF_DIR_P1:       s_next.rdata = s_reg.pm1;
				pxpu_pkg::OFF_DIR_P3:       s_next.rdata = s_reg.pm3;
				pxpu_pkg::OFF_DIR_P5:       s_next.rdata = s_reg.pm5;
				pxpu_pkg::OFF_DIR_P8:       s_next.rdata = s_reg.pm8;
				pxpu_pkg::OFF_DIR_P9:       s_next.rdata = s_reg.pm9;
				pxpu_pkg::OFF_ALT_P0:       s_next.rdata = s_reg.pmc0;
				pxpu_pkg::OFF_ALT_P3:       s_next.rdata = s_reg.pmc3;
				pxpu_pkg::OFF_ALT_P8:       s_next.rdata = s_reg.pmc8;
				default:                    s_next.rdata = pxpu_pkg::RST_ZERO;
			endcase
		end
		if (wr_i) begin
			case (addr_i)
				pxpu_pkg::OFF_MEM_EXP_CTRL:
					s_next.mm = (wdata_i & mm_wmask) |
						(s_reg.mm & ~mm_wmask & pxpu_pkg::MM_MASK_SIZE);
				pxpu_pkg::OFF_PU_OPT_LOW:
					s_next.pullup_option_low = wdata_i & pxpu_pkg::PUL_MASK;
				pxpu_pkg::OFF_PU_OPT_HIGH:
					s_next.pullup_option_high = wdata_i & pxpu_pkg::PUH_MASK;
				pxpu_pkg::OFF_DIR_P0: s_next.pm0 = wdata_i;
				pxpu_pkg::OFF_DIR_P1: s_next.pm1 = wdata_i;
				pxpu_pkg::OFF_DIR_P3:
					s_next.pm3 = wdata_i & pxpu_pkg::MASK_7BIT;
				pxpu_pkg::OFF_DIR_P5: s_next.pm5 = wdata_i;
				pxpu_pkg::OFF_DIR_P8:
					s_next.pm8 = wdata_i & pxpu_pkg::MASK_6BIT;
				pxpu_pkg::OFF_DIR_P9:
					s_next.pm9 = wdata_i & pxpu_pkg::MASK_4BIT;
				pxpu_pkg::OFF_ALT_P0: s_next.pmc0 = wdata_i;
				pxpu_pkg::OFF_ALT_P3:
					s_next.pmc3 = wdata_i & pxpu_pkg::MASK_7BIT;
				pxpu_pkg::OFF_ALT_P8:
					s_next.pmc8 = wdata_i & pxpu_pkg::MASK_6BIT;
				default: ;
			endcase
		end

		// Outputs follow the new register values at the same edge
		code   = s_next.mm[2:0];
		// Reserved 110 falls in with full expansion; 010 drives no bus but gives port 4 no pull-up
		exp_on = (code == pxpu_pkg::EXP_256) || code[2];
		s_next.p4_bus = exp_on;
		s_next.p4_out = (code == pxpu_pkg::EXP_SC_OUT);
		s_next.p9_bus = exp_on;
		case (code)
			pxpu_pkg::EXP_4K:  s_next.p5_addr = pxpu_pkg::ADDR_4K;
			pxpu_pkg::EXP_16K: s_next.p5_addr = pxpu_pkg::ADDR_16K;
			pxpu_pkg::EXP_FULL,
			pxpu_pkg::EXP_RSV_HI:
				s_next.p5_addr = pxpu_pkg::ADDR_FULL;
			default:           s_next.p5_addr = pxpu_pkg::ADDR_NONE;
		endcase

		// Direction one is input; alternate function masks the pull-up
		s_next.pu0 = {8{s_next.pullup_option_low[pxpu_pkg::PUL_P0]}} &
			~s_next.pmc0 & s_next.pm0;
		s_next.pu1 = {8{s_next.pullup_option_low[pxpu_pkg::PUL_P1]}} &
			s_next.pm1;
		s_next.pu3 = {7{s_next.pullup_option_low[pxpu_pkg::PUL_P3]}} &
			~s_next.pmc3[6:0] & s_next.pm3[6:0];
		s_next.pu8 = {6{s_next.pullup_option_high[pxpu_pkg::PUH_P8]}} &
			~s_next.pmc8[5:0] & s_next.pm8[5:0];
		// Pin 0 doubles as the NMI input and has no pull-up device
		s_next.pu2 = {{5{s_next.pullup_option_low[pxpu_pkg::PUL_P2]}}, 1'b0};
		s_next.pu4 = {8{s_next.pullup_option_low[pxpu_pkg::PUL_P4] &
			(code == pxpu_pkg::EXP_SC_IN)}};
		s_next.pu5 = {8{s_next.pullup_option_low[pxpu_pkg::PUL_P5] & ~exp_on}} &
			s_next.pm5;
		s_next.pu9 = {4{s_next.pullup_option_high[pxpu_pkg::PUH_P9] & ~exp_on}} &
			s_next.pm9[3:0];
	end

	// -----------------------------------------------------------------
	// Register
	// -----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg         <= '0;
			s_reg.mm      <= MM_RESET & (pxpu_pkg::MM_MASK_CODE |
				pxpu_pkg::MM_MASK_SIZE);
			// Options zero and pins inputs: nothing pulled up
			s_reg.pullup_option_low    <= pxpu_pkg::RST_ZERO;
			s_reg.pullup_option_high    <= pxpu_pkg::RST_ZERO;
			s_reg.pm0     <= pxpu_pkg::RST_DIR;
			s_reg.pm1     <= pxpu_pkg::RST_DIR;
			s_reg.pm3     <= pxpu_pkg::MASK_7BIT;
			s_reg.pm5     <= pxpu_pkg::RST_DIR;
			s_reg.pm8     <= pxpu_pkg::MASK_6BIT;
			s_reg.pm9     <= pxpu_pkg::MASK_4BIT;
			s_reg.p4_bus  <= 1'b0;
			s_reg.p9_bus  <= 1'b0;
			s_reg.p5_addr <= pxpu_pkg::ADDR_NONE;
		end else begin
			s_reg <= s_next;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign rdata_o    = s_reg.rdata;
	assign pu_p0_o    = s_reg.pu0;
	assign pu_p1_o    = s_reg.pu1;
	assign pu_p2_o    = s_reg.pu2;
	assign pu_p3_o    = s_reg.pu3;
	assign pu_p4_o    = s_reg.pu4;
	assign pu_p5_o    = s_reg.pu5;
	assign pu_p8_o    = s_reg.pu8;
	assign pu_p9_o    = s_reg.pu9;
	assign alt_p0_o   = s_reg.pmc0;
	assign alt_p3_o   = s_reg.pmc3[6:0];
	assign alt_p8_o   = s_reg.pmc8[5:0];
	assign dir_p0_o   = s_reg.pm0;
	assign dir_p1_o   = s_reg.pm1;
	assign dir_p3_o   = s_reg.pm3[6:0];
	assign dir_p5_o   = s_reg.pm5;
	assign dir_p8_o   = s_reg.pm8[5:0];
	assign dir_p9_o   = s_reg.pm9[3:0];
	assign p4_bus_o   = s_reg.p4_bus;
	assign p4_out_o   = s_reg.p4_out;
	assign p5_addr_o  = s_reg.p5_addr;
	assign p9_bus_o   = s_reg.p9_bus;
	assign mem_size_o = s_reg.mm[pxpu_pkg::MM_SIZE_LSB +: 2];

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	AST_MM_RSV_ZERO: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		(s_reg.mm[7] == 1'b0) && (s_reg.mm[4:3] == 2'b00))
		else $error("reserved expansion bits not zero");

	AST_PUO_TOP_ZERO: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		wr_i && (addr_i == pxpu_pkg::OFF_PU_OPT_HIGH) |=>
		(s_reg.pullup_option_high == ($past(wdata_i) & pxpu_pkg::PUH_MASK)))
		else $error("high option write not masked");

	AST_ALT_NO_PU: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		((pu_p0_o & alt_p0_o) == 8'h00) &&
		((pu_p3_o & alt_p3_o) == 7'h00) &&
		((pu_p8_o & alt_p8_o) == 6'h00))
		else $error("pull-up on alternate-function pin");

	AST_P2_NMI_FREE: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		s_reg.pullup_option_low[pxpu_pkg::PUL_P2] |-> (pu_p2_o == 6'h3E))
		else $error("port 2 pull-up pattern wrong");

	AST_EXP_PU_OFF: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		p4_bus_o |-> (pu_p4_o == 8'h00) && (pu_p5_o == 8'h00) &&
		(pu_p9_o == 4'h0))
		else $error("pull-up active in expansion mode");

	AST_P0_PU_EQ: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		pu_p0_o == ({8{s_reg.pullup_option_low[pxpu_pkg::PUL_P0]}} & ~alt_p0_o &
		dir_p0_o))
		else $error("port 0 pull-up mismatch");

	AST_WR_TRACK: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		wr_i && (addr_i == pxpu_pkg::OFF_PU_OPT_LOW) &&
		wdata_i[pxpu_pkg::PUL_P1] |=> (pu_p1_o == dir_p1_o))
		else $error("pull-up did not follow option write");

	AST_READ_NEXT: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		rd_i && (addr_i == pxpu_pkg::OFF_MEM_EXP_CTRL) |=>
		(rdata_o == $past(s_reg.mm)))
		else $error("expansion register read wrong");

	AST_4K_ADDR: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		(s_reg.mm[2:0] == pxpu_pkg::EXP_4K) |->
		(p5_addr_o == pxpu_pkg::ADDR_4K) && p4_bus_o)
		else $error("4K mode address lines wrong");

	AST_SIZE_FIXED: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!(SIZE_PROG && wr_i && (addr_i == pxpu_pkg::OFF_MEM_EXP_CTRL)) |=>
		$stable(mem_size_o))
		else $error("memory size changed without a size write");

	AST_SC_PORT: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		(s_reg.mm[2:0] == pxpu_pkg::EXP_SC_IN) ||
		(s_reg.mm[2:0] == pxpu_pkg::EXP_SC_OUT) |->
		!p4_bus_o && !p9_bus_o && (p5_addr_o == pxpu_pkg::ADDR_NONE) &&
		(p4_out_o == (s_reg.mm[2:0] == pxpu_pkg::EXP_SC_OUT)))
		else $error("single-chip code drives the bus");

	AST_256_BUS: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		(s_reg.mm[2:0] == pxpu_pkg::EXP_256) |->
		p4_bus_o && p9_bus_o && !p4_out_o &&
		(p5_addr_o == pxpu_pkg::ADDR_NONE))
		else $error("256-byte mode pin use wrong");

	AST_16K_ADDR: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		(s_reg.mm[2:0] == pxpu_pkg::EXP_16K) |->
		(p5_addr_o == pxpu_pkg::ADDR_16K) && p4_bus_o)
		else $error("16K mode address lines wrong");

	AST_FULL_ADDR: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		(s_reg.mm[2:0] == pxpu_pkg::EXP_FULL) |->
		(p5_addr_o == pxpu_pkg::ADDR_FULL) && p4_bus_o && p9_bus_o)
		else $error("full expansion pin use wrong");

	AST_P2_OFF: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!s_reg.pullup_option_low[pxpu_pkg::PUL_P2] |-> (pu_p2_o == 6'h00))
		else $error("port 2 pull-up without option");

	AST_P4_PU: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		pu_p4_o == {8{s_reg.pullup_option_low[pxpu_pkg::PUL_P4] &&
		(s_reg.mm[2:0] == pxpu_pkg::EXP_SC_IN)}})
		else $error("port 4 pull-up mismatch");

	AST_P5_PU: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!p4_bus_o |-> (pu_p5_o == ({8{s_reg.pullup_option_low[pxpu_pkg::PUL_P5]}} &
		dir_p5_o)))
		else $error("port 5 pull-up mismatch");

	AST_P9_PU: assert property (@(posedge mclk_i)
		disable iff (!rst_b_i)
		!p9_bus_o |-> (pu_p9_o == ({4{s_reg.pullup_option_high[pxpu_pkg::PUH_P9]}} &
		dir_p9_o)))
		else $error("port 9 pull-up mismatch");
endmodule : pxpu_top

// ---- verification/pxpu_pin_model.sv ----
// Pad model for port 4 as seen from the board side.
// Assumes the pull-up enables of the block under test drive it.
`timescale 1ns/1ps
module pxpu_pin_model (
	input  wire logic       mclk_i,
	input  wire logic [7:0] pu_p4_i,
	input  wire logic       p4_bus_i,
	output logic      [7:0] p4_level_o
);
	// An undriven pin is not a known level: toggle it every cycle
	logic [7:0] float_pat = 8'hA5;

	always @(posedge mclk_i) float_pat <= ~float_pat;

	// Pulled-up pins read high; bus pins are the memory's business
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			p4_level_o[i] = (pu_p4_i[i] && !p4_bus_i) ? 1'b1 :
				float_pat[i];
		end
	end
endmodule : pxpu_pin_model

// ---- verification/test_port_expansion_pullup_control.sv ----
// Self-checking bench for the expansion and pull-up block.
// Assumes the default product reset value and a programmable size field.
`timescale 1ns/1ps
module test_port_expansion_pullup_control;
	logic        mclk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [7:0]  rdata_o, pu_p0_o, pu_p1_o, pu_p4_o, pu_p5_o, alt_p0_o;
	logic [7:0]  dir_p0_o, dir_p1_o, dir_p5_o, p5_addr_o, p4_level;
	logic [5:0]  pu_p2_o, pu_p8_o, alt_p8_o, dir_p8_o;
	logic [6:0]  pu_p3_o, alt_p3_o, dir_p3_o;
	logic [3:0]  pu_p9_o, dir_p9_o;
	logic        p4_bus_o, p4_out_o, p9_bus_o;
	logic [1:0]  mem_size_o;
	int          fail_count = 0;
	int          tests_run = 0;
	int          cycles = 0;

	always #12.5 mclk_i = ~mclk_i;

	pxpu_top pxpu_top_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .pu_p0_o(pu_p0_o), .pu_p1_o(pu_p1_o),
		.pu_p2_o(pu_p2_o), .pu_p3_o(pu_p3_o), .pu_p4_o(pu_p4_o),
		.pu_p5_o(pu_p5_o), .pu_p8_o(pu_p8_o), .pu_p9_o(pu_p9_o),
		.alt_p0_o(alt_p0_o), .alt_p3_o(alt_p3_o), .alt_p8_o(alt_p8_o),
		.dir_p0_o(dir_p0_o), .dir_p1_o(dir_p1_o), .dir_p3_o(dir_p3_o),
		.dir_p5_o(dir_p5_o), .dir_p8_o(dir_p8_o), .dir_p9_o(dir_p9_o),
		.p4_bus_o(p4_bus_o), .p4_out_o(p4_out_o), .p5_addr_o(p5_addr_o),
		.p9_bus_o(p9_bus_o), .mem_size_o(mem_size_o));

	pxpu_pin_model pxpu_pin_model_inst (.mclk_i(mclk_i), .pu_p4_i(pu_p4_o),
		.p4_bus_i(p4_bus_o), .p4_level_o(p4_level));

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic summarize();
		$display("Mismatches %0d of %0d compares", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Register lands on the strobe edge; outputs sampled just after it
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		#1;
	endtask : reg_wr

	task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		check(rdata_o, exp);
	endtask : reg_rd

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_reset();
		check(pu_p0_o | pu_p1_o | pu_p4_o | pu_p5_o, 8'h00);
		check(8'(pu_p2_o | pu_p8_o) | 8'(pu_p9_o), 8'h00);
		check(dir_p0_o, 8'hFF);
		check(dir_p1_o & dir_p5_o, 8'hFF);
		check(8'(dir_p3_o), 8'h7F);
		check(8'(dir_p8_o), 8'h3F);
		check(8'(dir_p9_o), 8'h0F);
		check(alt_p0_o | 8'(alt_p3_o) | 8'(alt_p8_o), 8'h00);
		check({p4_bus_o, p9_bus_o, p4_out_o, 3'h0, mem_size_o}, 8'h00);
		check(p5_addr_o, 8'h00);
		reg_rd(pxpu_pkg::OFF_MEM_EXP_CTRL, pxpu_pkg::MM_RESET_C);
	endtask : t_reset

	task automatic t_options();
		reg_wr(pxpu_pkg::OFF_PU_OPT_LOW, 8'hFF);
		reg_rd(pxpu_pkg::OFF_PU_OPT_LOW, 8'h3F);
		reg_wr(pxpu_pkg::OFF_PU_OPT_HIGH, 8'hFF);
		reg_rd(pxpu_pkg::OFF_PU_OPT_HIGH, 8'h03);
		check(8'(pu_p2_o), 8'h3E);
		check(pu_p1_o, 8'hFF);
		check(8'(pu_p8_o), 8'h3F);
		check(p4_level, 8'hFF);
	endtask : t_options

	task automatic t_codes();
		// Reserved codes 010 and 110 are never written
		logic [2:0] code [6] = '{pxpu_pkg::EXP_SC_IN, pxpu_pkg::EXP_SC_OUT,
			pxpu_pkg::EXP_256, pxpu_pkg::EXP_4K, pxpu_pkg::EXP_16K,
			pxpu_pkg::EXP_FULL};
		logic [7:0] adr [6] = '{pxpu_pkg::ADDR_NONE, pxpu_pkg::ADDR_NONE,
			pxpu_pkg::ADDR_NONE, pxpu_pkg::ADDR_4K, pxpu_pkg::ADDR_16K,
			pxpu_pkg::ADDR_FULL};
		logic       sc;
		for (int i = 0; i < 6; i++) begin
			reg_wr(pxpu_pkg::OFF_MEM_EXP_CTRL, {5'h00, code[i]});
			sc = (i < 2);
			check(p5_addr_o, adr[i]);
			check({6'h00, p4_bus_o, p9_bus_o}, {6'h00, !sc, !sc});
			check({7'h00, p4_out_o}, {7'h00, i == 1});
			check(pu_p4_o, (i == 0) ? 8'hFF : 8'h00);
			check(pu_p5_o, sc ? 8'hFF : 8'h00);
			check(8'(pu_p9_o), sc ? 8'h0F : 8'h00);
		end
	endtask : t_codes

	task automatic t_mm_bits();
		reg_wr(pxpu_pkg::OFF_MEM_EXP_CTRL, 8'hFF);
		reg_rd(pxpu_pkg::OFF_MEM_EXP_CTRL, 8'h67);
		check(8'(mem_size_o), 8'h03);
		reg_wr(pxpu_pkg::OFF_MEM_EXP_CTRL, 8'h40);
		check(8'(mem_size_o), 8'h02);
	endtask : t_mm_bits

	task automatic t_port_pins();
		reg_wr(pxpu_pkg::OFF_MEM_EXP_CTRL, 8'h00);
		check(pu_p0_o, 8'hFF);
		check(8'(pu_p3_o), 8'h7F);
		reg_wr(pxpu_pkg::OFF_ALT_P0, 8'h0F);
		check(pu_p0_o, 8'hF0);
		check(alt_p0_o, 8'h0F);
		reg_wr(pxpu_pkg::OFF_DIR_P0, 8'h3C);
		check(pu_p0_o, 8'h30);
		check(dir_p0_o, 8'h3C);
		reg_wr(pxpu_pkg::OFF_DIR_P1, 8'hA5);
		check(pu_p1_o, 8'hA5);
		reg_wr(pxpu_pkg::OFF_ALT_P3, 8'hFF);
		check(8'(pu_p3_o), 8'h00);
		check(8'(alt_p3_o), 8'h7F);
		reg_wr(pxpu_pkg::OFF_DIR_P5, 8'h0F);
		check(pu_p5_o, 8'h0F);
		check(dir_p5_o, 8'h0F);
		reg_wr(pxpu_pkg::OFF_DIR_P9, 8'hF5);
		check(8'(pu_p9_o), 8'h05);
		check(8'(dir_p9_o), 8'h05);
		reg_wr(pxpu_pkg::OFF_ALT_P8, 8'hFF);
		check(8'(pu_p8_o), 8'h00);
		check(8'(alt_p8_o), 8'h3F);
		reg_rd(16'h1234, 8'h00);
		reg_rd(pxpu_pkg::OFF_ALT_P8, 8'h3F);
		// Read data must drop back to zero one cycle after it stood
		@(posedge mclk_i);
		#1;
		check(rdata_o, 8'h00);
	endtask : t_port_pins

	task automatic t_mid_reset();
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		#1;
		check(pu_p0_o | pu_p1_o | pu_p5_o, 8'h00);
		check(8'(pu_p2_o) | 8'(pu_p9_o), 8'h00);
		check(dir_p0_o, 8'hFF);
		reg_rd(pxpu_pkg::OFF_PU_OPT_LOW, 8'h00);
		reg_rd(pxpu_pkg::OFF_MEM_EXP_CTRL, pxpu_pkg::MM_RESET_C);
	endtask : t_mid_reset

	task automatic t_stop_prep();
		// Options cleared before a low-power stop
		reg_wr(pxpu_pkg::OFF_PU_OPT_LOW, 8'hFF);
		check(pu_p1_o, 8'hFF);
		reg_wr(pxpu_pkg::OFF_PU_OPT_LOW, 8'h00);
		reg_wr(pxpu_pkg::OFF_PU_OPT_HIGH, 8'h00);
		check(pu_p1_o | pu_p5_o | 8'(pu_p2_o), 8'h00);
	endtask : t_stop_prep

	// -----------------------------------------------------------------
	// Main sequence and hang guard
	// -----------------------------------------------------------------
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		#1;
		t_reset();
		t_options();
		t_codes();
		t_mm_bits();
		t_port_pins();
		t_mid_reset();
		t_stop_prep();
		summarize();
	end
endmodule : test_port_expansion_pullup_control
